//--- core/tlvic_pkg.sv
// Operation
// - Sixteen maskable sources plus reset vector
// - Software-set pending flag acts like hardware
// - One priority bit per source, low/high
// - High request preempts active low routine
// - Active high routine blocks every request
// - Priority bits reset to low
// - High level served before low level
// - Same level: lowest rank number wins
// - Requests sampled and decoded every cycle
// - One detect cycle, then core call
// - One instruction runs after return first
// - Worst case covered by return hold
// - Equal or lower waits for return
// - Vector 0x0003 plus eight per rank
// - Global enable bit 7 overrides masks
// - Bit 6 masks all four serial flags
// - Bit 5 enables either timer2 flag
// - Enable register at 0xA8, resets zero
// - Flags set regardless of enable state
// - Edge and timer0/1 flags auto-clear
// - Still-set flag re-requests after return
package tlvic_pkg;

  // ==========================================================
  // Source slots
  localparam int             NUM_SLOTS      = 17;
  localparam int             IDX_W          = 5;
  localparam int             SLOT_TIMER2    = 5;
  localparam int             SLOT_SERIAL    = 6;
  localparam int             SLOT_CAP_GT    = 16;
  localparam int             BASE_SLOTS     = 7;   // Slots held in the primary registers
  localparam int             EXT_SLOTS      = 10;  // Slots held in the extended registers
  localparam logic [16:0]    SLOT_VALID     = 17'h1DFFF; // Rank 13 reserved
  localparam logic [16:0]    AUTO_CLR_MASK  = 17'h0000F; // Edge and timer0/1 slots

  // ==========================================================
  // Vectors
  localparam logic [15:0]    RESET_VECTOR   = 16'h0000;
  localparam logic [15:0]    VEC_BASE       = 16'h0003;
  localparam int             VEC_SHIFT      = 3;   // Step of eight bytes

  // ==========================================================
  // Register byte offsets (low address byte)
  localparam logic [7:0]     OFS_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0]     OFS_PRIO_SEL   = 8'hB8;
  localparam logic [7:0]     OFS_EXT_ENABLE = 8'hC0;
  localparam logic [7:0]     OFS_EXT_PRIO   = 8'hC4;
  localparam logic [7:0]     OFS_SOFT_PEND  = 8'hC8;
  localparam logic [7:0]     OFS_STATUS     = 8'hCC;
  localparam logic [7:0]     OFS_PEND_VIEW  = 8'hD0;

  // ==========================================================
  // Field positions and reset values
  localparam int             BIT_GLOBAL_EN  = 7;
  localparam int             BIT_SERIAL_EN  = 6;
  localparam int             BIT_TIMER2_EN  = 5;
  localparam logic [7:0]     IRQ_ENABLE_RST = 8'h00;
  localparam logic [6:0]     PRIO_SEL_RST   = 7'h00;
  localparam logic [9:0]     EXT_RST        = 10'h000;
  localparam logic [16:0]    PEND_RST       = 17'h00000;
  localparam logic           PRIO_TOP_READ  = 1'b1;  // Unused top bit reads one

  // ==========================================================
  // Bus encodings
  localparam logic [1:0]     HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]     HSIZE_WORD     = 3'h2;
  localparam logic           HRESP_OKAY     = 1'b0;

  // Sequencer after a return instruction
  typedef enum logic [1:0] {
    TLVIC_RUN       = 2'h1,
    TLVIC_AFTER_RET = 2'h2
  } tlvic_seq_t;

endpackage

//--- core/tlvic_top.sv
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module tlvic_top (
  input  wire logic        CLK,                      // System clock, 50 MHz
  input  wire logic        ARST_N,                   // Async reset, active low
  // AHB-Lite slave
  input  wire logic        HSEL,                     // Slave select
  input  wire logic [31:0] HADDR,                    // Byte address
  input  wire logic [1:0]  HTRANS,                   // Transfer type
  input  wire logic        HWRITE,                   // Write when high
  input  wire logic [2:0]  HSIZE,                    // Transfer size
  input  wire logic [31:0] HWDATA,                   // Write data
  input  wire logic        HREADY,                   // Bus ready
  output logic      [31:0] HRDATA,                   // Read data
  output logic             HREADYOUT,                // Slave ready
  output logic             HRESP,                    // Always OKAY
  // Event pulses for the self-held flags
  input  wire logic        EXT_IRQ0_INPUT,           // Edge event, rank 0
  input  wire logic        TIMER0_OVF_EVT,           // Overflow event, rank 1
  input  wire logic        EXT_IRQ1_INPUT,           // Edge event, rank 2
  input  wire logic        TIMER1_OVF_EVT,           // Overflow event, rank 3
  // Peripheral-held pending levels
  input  wire logic [16:0] PERIPH_PEND,              // One level per rank
  input  wire logic        TIMER2_LOW_OVERFLOW_FLAG, // Timer2 low byte
  input  wire logic        TIMER2_HIGH_OVERFLOW_FLAG,// Timer2 high byte
  input  wire logic        XFER_DONE_FLAG,           // Serial transfer done
  input  wire logic        WRITE_COLLISION_FLAG,     // Serial collision
  input  wire logic        MODE_FAULT_FLAG,          // Serial mode fault
  input  wire logic        RX_OVERRUN_FLAG,          // Serial overrun
  input  wire logic        CAP_SENSE_GT_FLAG,        // Cap sense compare
  // Core handshake
  input  wire logic        CORE_ACK,                 // Call to vector taken
  input  wire logic        CORE_RETURN_FROM_IRQ_INSTR_DONE,           // Return completed
  input  wire logic        CORE_INSTR_DONE,          // Instruction completed
  output logic             IRQ_REQ,                  // Request to core
  output logic      [15:0] IRQ_VECTOR,               // Selected vector
  output logic             IRQ_HIGH                  // Request is high level
);

  // ==========================================================
  // Rank picker: lowest set index wins
  function automatic logic [4:0] pick_rank(input logic [16:0] req);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = tlvic_pkg::NUM_SLOTS - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  // ==========================================================
  // State
  logic [7:0]             irq_enable_reg;
  logic [6:0]             priority_select_reg;
  logic [9:0]             ext_irq_enable_reg;
  logic [9:0]             ext_priority_select_reg;
  logic [16:0]            pend_flag;
  logic                   lo_active;
  logic                   hi_active;
  tlvic_pkg::tlvic_seq_t  seq;
  logic [4:0]             req_rank;
  logic                   ap_valid;
  logic                   ap_write;
  logic [7:0]             ap_addr;

  // ==========================================================
  // Bus address phase decode
  wire                    bus_take   = HSEL & HREADY & (HTRANS == tlvic_pkg::HTRANS_NONSEQ);
  wire                    wr_ok      = ap_valid & ap_write;
  wire                    wr_ie      = wr_ok & (ap_addr == tlvic_pkg::OFS_IRQ_ENABLE);
  wire                    wr_ip      = wr_ok & (ap_addr == tlvic_pkg::OFS_PRIO_SEL);
  wire                    wr_eie     = wr_ok & (ap_addr == tlvic_pkg::OFS_EXT_ENABLE);
  wire                    wr_eip     = wr_ok & (ap_addr == tlvic_pkg::OFS_EXT_PRIO);
  wire                    wr_pend    = wr_ok & (ap_addr == tlvic_pkg::OFS_SOFT_PEND);
  wire [7:0]              rd_addr    = HADDR[7:0];

  // ==========================================================
  // Per-slot pending levels; flags count whatever the enables
  wire                    timer2_any = TIMER2_LOW_OVERFLOW_FLAG | TIMER2_HIGH_OVERFLOW_FLAG;
  wire                    serial_any = XFER_DONE_FLAG | WRITE_COLLISION_FLAG
                                     | MODE_FAULT_FLAG | RX_OVERRUN_FLAG;
  wire [16:0]             hw_set     = {13'h0000, TIMER1_OVF_EVT, EXT_IRQ1_INPUT,
                                        TIMER0_OVF_EVT, EXT_IRQ0_INPUT};
  wire [16:0]             dedicated  = (17'(timer2_any) << tlvic_pkg::SLOT_TIMER2)
                                     | (17'(serial_any) << tlvic_pkg::SLOT_SERIAL)
                                     | (17'(CAP_SENSE_GT_FLAG) << tlvic_pkg::SLOT_CAP_GT);
  // Software-set flags merge with hardware ones, no difference downstream
  wire [16:0]             pending    = (PERIPH_PEND | dedicated | pend_flag)
                                     & tlvic_pkg::SLOT_VALID;

  // ==========================================================
  // Enables and priority per slot
  wire [16:0]             slot_en    = {ext_irq_enable_reg,
                                        irq_enable_reg[tlvic_pkg::BASE_SLOTS-1:0]};
  wire [16:0]             slot_hi    = {ext_priority_select_reg, priority_select_reg};
  wire                    global_en  = irq_enable_reg[tlvic_pkg::BIT_GLOBAL_EN];
  wire [16:0]             eligible   = pending & slot_en & {17{global_en}};

  // ==========================================================
  // Arbitration, redone every cycle from fresh levels
  wire                    hold_ret   = (seq == tlvic_pkg::TLVIC_AFTER_RET) | CORE_RETURN_FROM_IRQ_INSTR_DONE;
  wire [16:0]             cand_hi    = eligible & slot_hi;
  wire [16:0]             cand_lo    = eligible & ~slot_hi;
  wire                    allow_hi   = ~hi_active & ~hold_ret;
  wire                    allow_lo   = ~hi_active & ~lo_active & ~hold_ret;
  wire                    take_hi    = allow_hi & (|cand_hi);
  wire                    take_lo    = allow_lo & (|cand_lo) & ~take_hi;
  wire [4:0]              rank_hi    = pick_rank(cand_hi);
  wire [4:0]              rank_lo    = pick_rank(cand_lo);
  wire [4:0]              next_rank  = take_hi ? rank_hi : rank_lo;
  // Request dropped in the acknowledge cycle so a stale vector is never reused
  wire                    next_req   = (take_hi | take_lo) & ~(CORE_ACK & IRQ_REQ);
  wire [15:0]             next_vec   = tlvic_pkg::VEC_BASE
                                     + 16'({next_rank, 3'b000});
  wire                    acked      = CORE_ACK & IRQ_REQ;

  // ==========================================================
  // Auto-clear of the self-held flags on vectoring
  wire [16:0]             ack_onehot = 17'(1) << req_rank;
  wire [16:0]             auto_clr   = acked ? (ack_onehot & tlvic_pkg::AUTO_CLR_MASK)
                                             : 17'h00000;
  wire [16:0]             pend_base  = wr_pend ? (HWDATA[16:0] & tlvic_pkg::SLOT_VALID)
                                               : pend_flag;
  // New events win over both software clear and auto-clear
  wire [16:0]             next_pend  = (pend_base & ~auto_clr) | hw_set;

  // ==========================================================
  // Active level tracking from the core's entry and return
  wire                    next_hi    = acked ? (hi_active | IRQ_HIGH)
                                             : (CORE_RETURN_FROM_IRQ_INSTR_DONE ? 1'b0 : hi_active);
  wire                    next_lo    = (acked & ~IRQ_HIGH) ? 1'b1
                                     : ((CORE_RETURN_FROM_IRQ_INSTR_DONE & ~hi_active) ? 1'b0 : lo_active);

  // ==========================================================
  // Sequencer: hold requests until one instruction after return
  tlvic_pkg::tlvic_seq_t  next_seq;
  always_comb begin
    next_seq = seq;
    case (seq)
      tlvic_pkg::TLVIC_RUN: begin
        if (CORE_RETURN_FROM_IRQ_INSTR_DONE) begin
          next_seq = tlvic_pkg::TLVIC_AFTER_RET;
        end
      end
      tlvic_pkg::TLVIC_AFTER_RET: begin
        if (CORE_INSTR_DONE) begin
          next_seq = tlvic_pkg::TLVIC_RUN;
        end
      end
      default: begin
        next_seq = tlvic_pkg::TLVIC_RUN;
      end
    endcase
  end

  // ==========================================================
  // Read mux for the address phase
  wire [31:0]             status_word = {20'h00000, 3'h0, req_rank, seq, hi_active, lo_active};
  logic [31:0]            rd_word;
  always_comb begin
    case (rd_addr)
      tlvic_pkg::OFS_IRQ_ENABLE: rd_word = {24'h000000, irq_enable_reg};
      tlvic_pkg::OFS_PRIO_SEL:   rd_word = {24'h000000, tlvic_pkg::PRIO_TOP_READ, priority_select_reg};
      tlvic_pkg::OFS_EXT_ENABLE: rd_word = {22'h000000, ext_irq_enable_reg};
      tlvic_pkg::OFS_EXT_PRIO:   rd_word = {22'h000000, ext_priority_select_reg};
      tlvic_pkg::OFS_SOFT_PEND:  rd_word = {15'h0000, pend_flag};
      tlvic_pkg::OFS_STATUS:     rd_word = status_word;
      tlvic_pkg::OFS_PEND_VIEW:  rd_word = {15'h0000, pending};
      default:                   rd_word = 32'h00000000;  // Unmapped reads zero
    endcase
  end

  // ==========================================================
  // Bus pipeline registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ap_valid  <= 1'b0;
      ap_write  <= 1'b0;
      ap_addr   <= 8'h00;
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= tlvic_pkg::HRESP_OKAY;
    end else begin
      ap_valid  <= bus_take;
      ap_write  <= HWRITE & (HSIZE == tlvic_pkg::HSIZE_WORD);  // Only whole words write
      ap_addr   <= rd_addr;
      HRDATA    <= (bus_take & ~HWRITE) ? rd_word : 32'h00000000;
      HREADYOUT <= 1'b1;                                       // Zero wait states
      HRESP     <= tlvic_pkg::HRESP_OKAY;
    end
  end

  // ==========================================================
  // Software-visible registers
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_enable_reg          <= tlvic_pkg::IRQ_ENABLE_RST;
      priority_select_reg     <= tlvic_pkg::PRIO_SEL_RST;
      ext_irq_enable_reg      <= tlvic_pkg::EXT_RST;
      ext_priority_select_reg <= tlvic_pkg::EXT_RST;
      pend_flag               <= tlvic_pkg::PEND_RST;
    end else begin
      if (wr_ie) begin
        irq_enable_reg <= HWDATA[7:0];
      end
      if (wr_ip) begin
        priority_select_reg <= HWDATA[6:0];
      end
      if (wr_eie) begin
        ext_irq_enable_reg <= HWDATA[9:0];
      end
      if (wr_eip) begin
        ext_priority_select_reg <= HWDATA[9:0];
      end
      pend_flag <= next_pend;
    end
  end

  // ==========================================================
  // In-service tracking and sequencer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      hi_active <= 1'b0;
      lo_active <= 1'b0;
      seq       <= tlvic_pkg::TLVIC_RUN;
    end else begin
      hi_active <= next_hi;
      lo_active <= next_lo;
      seq       <= next_seq;
    end
  end

  // ==========================================================
  // Request to the core: one registered detect cycle
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_REQ    <= 1'b0;
      IRQ_VECTOR <= tlvic_pkg::RESET_VECTOR;
      IRQ_HIGH   <= 1'b0;
      req_rank   <= 5'h00;
    end else begin
      IRQ_REQ    <= next_req;
      IRQ_VECTOR <= next_req ? next_vec : IRQ_VECTOR;
      IRQ_HIGH   <= next_req ? take_hi : IRQ_HIGH;
      req_rank   <= next_req ? next_rank : req_rank;
    end
  end

endmodule

//--- sim/tlvic_top_asserts.sv
`timescale 1ns/1ps
module tlvic_top_asserts (
  input wire logic        CLK,             // Clock
  input wire logic        ARST_N,          // Reset
  input wire logic        HSEL,            // Select
  input wire logic [31:0] HADDR,           // Address
  input wire logic [1:0]  HTRANS,          // Transfer
  input wire logic        HWRITE,          // Direction
  input wire logic [2:0]  HSIZE,           // Size
  input wire logic [31:0] HWDATA,          // Write data
  input wire logic        HREADY,          // Bus ready
  input wire logic [31:0] HRDATA,          // Read data
  input wire logic        HREADYOUT,       // Slave ready
  input wire logic        HRESP,           // Response
  input wire logic        EXT_IRQ0_INPUT,  // Rank 0 event
  input wire logic        CORE_ACK,        // Call taken
  input wire logic        CORE_RETURN_FROM_IRQ_INSTR_DONE,  // Return done
  input wire logic        CORE_INSTR_DONE, // Instruction done
  input wire logic        IRQ_REQ,         // Request
  input wire logic [15:0] IRQ_VECTOR,      // Vector
  input wire logic        IRQ_HIGH         // High level
);
  // ==========================================================
  // Shadow of the enable register and of the active levels
  logic       wr_ph, rd_ph, hi_act, lo_act, hold;
  logic [7:0] ie;
  wire        addr_ok = HSEL && HREADY && HTRANS == tlvic_pkg::HTRANS_NONSEQ;
  wire        ie_wr   = addr_ok && HWRITE && HSIZE == tlvic_pkg::HSIZE_WORD && HADDR[7:0] == tlvic_pkg::OFS_IRQ_ENABLE;
  wire        took    = CORE_ACK && IRQ_REQ;
  // Nested return ends the high level first
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {wr_ph, rd_ph, hi_act, lo_act, hold, ie} <= '0;
    end else begin
      wr_ph <= ie_wr;
      rd_ph <= addr_ok && !HWRITE;
      ie <= wr_ph ? HWDATA[7:0] : ie;
      hold <= CORE_RETURN_FROM_IRQ_INSTR_DONE || (hold && !CORE_INSTR_DONE);
      hi_act <= (took && IRQ_HIGH) || (hi_act && !CORE_RETURN_FROM_IRQ_INSTR_DONE);
      lo_act <= (took && !IRQ_HIGH) || (lo_act && !(CORE_RETURN_FROM_IRQ_INSTR_DONE && !hi_act));
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_quiet2; !IRQ_REQ ##1 !IRQ_REQ; endsequence
  sequence s_idle; !IRQ_REQ && !CORE_ACK && !hi_act && !lo_act && !hold; endsequence
  a_bus_okay: assert property (HREADYOUT && HRESP == tlvic_pkg::HRESP_OKAY)
    else $error("bus answer not ready and okay");
  a_rdata_idle: assert property (!rd_ph |-> HRDATA == 32'h0)
    else $error("read data outside read data phase");
  a_global_off: assert property (!ie[7] |=> !IRQ_REQ)
    else $error("request while globally disabled");
  a_vec_shape: assert property (IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR <= 16'h0083 && IRQ_VECTOR != 16'h006B)
    else $error("vector outside the table");
  a_drop_on_ack: assert property (took |=> !IRQ_REQ)
    else $error("request held after call taken");
  a_high_blocks: assert property (hi_act |-> !IRQ_REQ)
    else $error("request during high routine");
  a_low_preempt: assert property (lo_act && !hi_act && IRQ_REQ |-> IRQ_HIGH)
    else $error("low request during low routine");
  a_ret_hold: assert property (hold |-> s_quiet2)
    else $error("request before the instruction after return");
  a_fast_detect: assert property (EXT_IRQ0_INPUT && ie[7] && ie[0] ##0 s_idle |-> ##2 IRQ_REQ)
    else $error("event not requested after one detect cycle");
endmodule

bind tlvic_top tlvic_top_asserts u_asserts (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EXT_IRQ0_INPUT(EXT_IRQ0_INPUT), .CORE_ACK(CORE_ACK),
  .CORE_RETURN_FROM_IRQ_INSTR_DONE(CORE_RETURN_FROM_IRQ_INSTR_DONE), .CORE_INSTR_DONE(CORE_INSTR_DONE), .IRQ_REQ(IRQ_REQ),
  .IRQ_VECTOR(IRQ_VECTOR), .IRQ_HIGH(IRQ_HIGH));

//--- sim/tlvic_core_model.sv
`timescale 1ns/1ps
module tlvic_core_model (
  input  wire logic clk,             // System clock
  input  wire logic irq_req,         // Request from controller
  output logic      ack = 1'b0,      // Call taken
  output logic      return_from_irq_instr_done = 1'b0,// Return completed
  output logic      instr_done = 1'b0// Instruction completed
);
  // ==========================================================
  // Call: stalls model a long instruction before the boundary
  task automatic take(input int stall);
    repeat (stall) @(posedge clk);
    @(posedge clk);
    ack <= irq_req;
    @(posedge clk);
    ack <= 1'b0;
  endtask

  // Return, then one instruction of len cycles (a divide is 8)
  task automatic ret(input int len);
    @(posedge clk);
    return_from_irq_instr_done <= 1'b1;
    @(posedge clk);
    return_from_irq_instr_done <= 1'b0;
    repeat (len - 1) @(posedge clk);
    instr_done <= 1'b1;
    @(posedge clk);
    instr_done <= 1'b0;
  endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Stimulus and bookkeeping
  logic        clk = 1'b0, arst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, n;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, irq_req, irq_high, ack, return_from_irq_instr, instr;
  logic [15:0] irq_vector;
  logic [3:0]  evt = 4'h0;  // Rank 0..3 events
  logic [7:0]  lvl = 8'h00; // Uart, timer2 x2, serial x4, cap sense
  logic [2:0]  hsize = tlvic_pkg::HSIZE_WORD; // Transfer size driven per call
  logic [16:0] pp = 17'h00000; // Extra peripheral levels per rank
  int          error_cnt = 0, num_checks = 0, i;
  always #10 clk = ~clk;

  tlvic_top dut (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .EXT_IRQ0_INPUT(evt[0]), .TIMER0_OVF_EVT(evt[1]), .EXT_IRQ1_INPUT(evt[2]),
    .TIMER1_OVF_EVT(evt[3]), .PERIPH_PEND(pp | {12'h000, lvl[0], 4'h0}), .TIMER2_LOW_OVERFLOW_FLAG(lvl[1]),
    .TIMER2_HIGH_OVERFLOW_FLAG(lvl[2]), .XFER_DONE_FLAG(lvl[3]), .WRITE_COLLISION_FLAG(lvl[4]),
    .MODE_FAULT_FLAG(lvl[5]), .RX_OVERRUN_FLAG(lvl[6]), .CAP_SENSE_GT_FLAG(lvl[7]), .CORE_ACK(ack),
    .CORE_RETURN_FROM_IRQ_INSTR_DONE(return_from_irq_instr), .CORE_INSTR_DONE(instr), .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_HIGH(irq_high));
  tlvic_core_model core (.clk(clk), .irq_req(irq_req), .ack(ack), .return_from_irq_instr_done(return_from_irq_instr), .instr_done(instr));

  // ==========================================================
  // Tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded wait for the slave; a hang ends the run
  task automatic wait_rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      chk("hready", 32'h1, 32'h0);
      complete_run();
    end
  endtask
  // Single word transfer; read data kept in rv
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= tlvic_pkg::HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rv = hrdata;
  endtask
  // n counts edges until the request shows; 0xFF when none came
  task automatic wait_req(input int lim);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (irq_req !== 1'b1 && n < lim);
    if (irq_req !== 1'b1) n = 32'hFF;
  endtask
  task automatic expect_vec(input logic [31:0] lat, input logic [31:0] rank);
    wait_req(40);
    if (lat != 0) chk("latency", lat, n);
    chk("vector", 32'h3 + (rank << 3), {16'h0, irq_vector});
  endtask

  // ==========================================================
  // Main sequence; latency 2 is the flag capture plus one detect cycle
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    bus(1'b0, tlvic_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("enable reset", 32'h00, rv);
    bus(1'b0, tlvic_pkg::OFS_PRIO_SEL, 32'h0);
    chk("priority reset", 32'h80, rv);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped read", 32'h0, rv);
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'h8F);
    bus(1'b0, tlvic_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("enable readback", 32'h8F, rv);
    // Byte-sized write must leave the register alone
    hsize <= 3'h0;
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'hFF);
    hsize <= tlvic_pkg::HSIZE_WORD;
    bus(1'b0, tlvic_pkg::OFS_IRQ_ENABLE, 32'h0);
    chk("byte write ignored", 32'h8F, rv);
    for (i = 0; i < 4; i++) begin
      evt <= 4'(4'h1 << i);
      @(posedge clk);
      evt <= 4'h0;
      expect_vec(2, i);
      core.take(i);
      bus(1'b0, tlvic_pkg::OFS_PEND_VIEW, 32'h0);
      chk("auto clear", 32'h0, rv & (32'h1 << i));
      core.ret(1);
    end
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'h01);
    bus(1'b1, tlvic_pkg::OFS_SOFT_PEND, 32'h1);
    wait_req(10);
    chk("global off", 32'hFF, n);
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'h81);
    expect_vec(0, 0);
    core.take(0);
    core.ret(1);
    // Uart and serial together: rank order, then preemption and nesting
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'hF0);
    bus(1'b1, tlvic_pkg::OFS_EXT_ENABLE, 32'h200);
    lvl <= 8'h09;
    expect_vec(0, 4);
    core.take(2);
    bus(1'b1, tlvic_pkg::OFS_PRIO_SEL, 32'h40);
    expect_vec(0, 6);
    chk("high level", 32'h1, {31'h0, irq_high});
    core.take(0);
    wait_req(10);
    chk("high blocks", 32'hFF, n);
    lvl <= 8'h01;
    core.ret(3);
    wait_req(10);
    chk("low waits", 32'hFF, n);
    core.ret(8);
    expect_vec(2, 4);
    core.take(0);
    lvl <= 8'h00;
    core.ret(1);
    // Every flag alone, including both timer2 halves and all serial flags
    for (i = 0; i < 8; i++) begin
      lvl <= 8'(8'h1 << i);
      expect_vec(0, (i == 0) ? 4 : (i < 3) ? 5 : (i < 7) ? 6 : 16);
      core.take(1);
      lvl <= 8'h00;
      core.ret(1);
    end
    bus(1'b1, tlvic_pkg::OFS_IRQ_ENABLE, 32'h90);
    lvl <= 8'h7E;
    wait_req(10);
    chk("masked groups", 32'hFF, n);
    lvl <= 8'h00;
    // Extended ranks: reserved rank ignored, rank 7 vectored
    bus(1'b1, tlvic_pkg::OFS_EXT_ENABLE, 32'h3FF);
    pp <= 17'h02000;
    wait_req(10);
    chk("reserved rank", 32'hFF, n);
    pp <= 17'h00080;
    expect_vec(0, 7);
    core.take(0);
    pp <= 17'h00000;
    core.ret(1);
    complete_run();
  end
endmodule
